//--- hw/sfsa_pkg.sv
package sfsa_pkg;
   localparam int NREG     = 8;
   localparam int TAG_W    = 2;
   localparam int TAGS_W   = NREG * TAG_W;
   localparam int FREG_W   = 80;
   localparam int SIMD_W   = 64;
   localparam int TOP_W    = 3;
   localparam int ADDR_W   = 8;
   localparam int FEAT_BIT = 23;

   localparam logic [TAG_W-1:0]  TAG_VALID  = 2'h0;
   localparam logic [TAG_W-1:0]  TAG_EMPTY  = 2'h3;
   localparam logic [TAGS_W-1:0] TAGS_VALID = 16'h0000;
   localparam logic [TAGS_W-1:0] TAGS_EMPTY = 16'hffff;
   localparam logic [15:0]       EXP_ONES   = 16'hffff;
   localparam logic [TOP_W-1:0]  TOP_CLEAR  = 3'h0;
   localparam logic [TOP_W-1:0]  LAST_IDX   = 3'h7;
   localparam logic [31:0]       LEAF_FEAT  = 32'h0000_0001;

   localparam logic [ADDR_W-1:0] A_CTRL  = 8'h00;
   localparam logic [ADDR_W-1:0] A_STAT  = 8'h04;
   localparam logic [ADDR_W-1:0] A_MASK  = 8'h08;
   localparam logic [ADDR_W-1:0] A_TAGS  = 8'h0c;
   localparam logic [ADDR_W-1:0] A_TOP   = 8'h10;
   localparam logic [ADDR_W-1:0] A_IDENT = 8'h14;

   localparam int CTRL_W     = 3;
   localparam int CTRL_EMU   = 0;
   localparam int CTRL_SIMD  = 1;
   localparam int CTRL_IDENT = 2;
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h6;

   localparam int EV_W       = 4;
   localparam int EV_EMU     = 0;
   localparam int EV_UNIMPL  = 1;
   localparam int EV_NOIDENT = 2;
   localparam int EV_EMPTY   = 3;

   typedef enum logic [2:0] {
      OP_NONE   = 3'h0,
      OP_PACKED = 3'h1,
      OP_EMPTY  = 3'h2,
      OP_FSTACK = 3'h3,
      OP_IDENT  = 3'h4,
      OP_SAVE   = 3'h5
   } sfsa_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SAVE = 2'b10
   } sfsa_state_e;

   typedef struct packed {
      logic              valid;
      sfsa_op_e          op;
      logic              impl;
      logic              wr;
      logic [TOP_W-1:0]  idx;
      logic [FREG_W-1:0] data;
      logic [31:0]       leaf;
      logic [TAGS_W-1:0] fpu_tags;
      logic [TOP_W-1:0]  fpu_top;
   } sfsa_retire_s;

   typedef struct packed {
      logic        fault;
      logic        ident_valid;
      logic [31:0] ident_d;
   } sfsa_resp_s;

   typedef struct packed {
      logic              valid;
      logic [TOP_W-1:0]  idx;
      logic [FREG_W-1:0] data;
   } sfsa_save_s;
endpackage

//--- hw/sfsa_stack.sv
`timescale 1ns/1ns
module sfsa_stack (
   input  wire logic                       clk_sys,
   input  wire logic                       we,
   input  wire logic [sfsa_pkg::TOP_W-1:0]  widx,
   input  wire logic [sfsa_pkg::FREG_W-1:0] wdata,
   input  wire logic [sfsa_pkg::TOP_W-1:0]  ridx,
   output logic      [sfsa_pkg::FREG_W-1:0] rdata
);
   import sfsa_pkg::*;

   // one physical file: packed-integer and stack ops share these words
   logic [FREG_W-1:0] mem [NREG];

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[widx] <= wdata;
      end
   end

   assign rdata = mem[ridx];
endmodule

//--- hw/sfsa_top.sv
`timescale 1ns/1ns
module sfsa_top (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic      [31:0]                hrdata,
   input  wire sfsa_pkg::sfsa_retire_s     ret,
   output logic                            retire_ready,
   output sfsa_pkg::sfsa_resp_s            resp,
   output sfsa_pkg::sfsa_save_s            save,
   output logic [sfsa_pkg::TAGS_W-1:0]     tag_word,
   output logic [sfsa_pkg::TOP_W-1:0]      stack_top_pointer,
   output logic                            irq
);
   import sfsa_pkg::*;

   logic [CTRL_W-1:0] control_reg_zero;
   logic [EV_W-1:0]   status;
   logic [EV_W-1:0]   mask;
   logic              wr_pend;
   logic [ADDR_W-1:0] wr_addr;
   sfsa_state_e       state;
   logic [TOP_W-1:0]  cnt;

   // bus decode; size is ignored since only whole words are mapped
   wire               take     = hsel && hready && htrans[1];
   wire               in_win   = ~|haddr[31:ADDR_W];
   wire [ADDR_W-1:0]  a        = haddr[ADDR_W-1:0];
   wire               rd_take  = take && !hwrite;
   wire               wr_take  = take && hwrite;
   wire               wr_go    = wr_pend && hready;
   wire               wr_ctrl  = wr_go && wr_addr == A_CTRL;
   wire               wr_stat  = wr_go && wr_addr == A_STAT;
   wire               wr_mask  = wr_go && wr_addr == A_MASK;
   wire [31:0]        rd_mux   =
      !in_win      ? 32'h0000_0000 :
      a == A_CTRL  ? 32'(control_reg_zero) :
      a == A_STAT  ? 32'(status) :
      a == A_MASK  ? 32'(mask) :
      a == A_TAGS  ? 32'(tag_word) :
      a == A_TOP   ? 32'(stack_top_pointer) :
      a == A_IDENT ? resp.ident_d : 32'h0000_0000;

   // retire decode and fault checks; a faulted op has no side effects
   wire emu_on   = control_reg_zero[CTRL_EMU];
   wire fpu_emulation_bit = emu_on;
   wire acc      = ret.valid && retire_ready;
   wire is_simd  = ret.op == OP_PACKED || ret.op == OP_EMPTY;
   wire f_emu    = acc && is_simd && fpu_emulation_bit;
   wire f_unimpl = acc && is_simd && !fpu_emulation_bit &&
                   (!control_reg_zero[CTRL_SIMD] || !ret.impl);
   wire f_noid   = acc && ret.op == OP_IDENT &&
                   !control_reg_zero[CTRL_IDENT];
   wire invalid_opcode_fault = f_emu || f_unimpl || f_noid;
   wire ok        = acc && !invalid_opcode_fault;
   wire do_packed = ok && ret.op == OP_PACKED;
   wire do_empty  = ok && ret.op == OP_EMPTY;
   wire do_fstack = ok && ret.op == OP_FSTACK;
   wire do_ident  = ok && ret.op == OP_IDENT;
   wire do_save   = ok && ret.op == OP_SAVE;

   // ident answer: feature flag only for the feature leaf
   wire [31:0] feat_word = 32'(control_reg_zero[CTRL_SIMD]) << FEAT_BIT;
   wire [31:0] ident_val = (ret.leaf == LEAF_FEAT) ?
                           feat_word : 32'h0000_0000;

   // tag word, one field per shared register
   logic [TAGS_W-1:0] next_tags;
   for (genvar g = 0; g < NREG; g++) begin : g_tag
      assign next_tags[g*TAG_W +: TAG_W] =
         do_empty  ? TAG_EMPTY :
         do_packed ? TAG_VALID :
         do_fstack ? ret.fpu_tags[g*TAG_W +: TAG_W] :
                     tag_word[g*TAG_W +: TAG_W];
   end

   wire [TOP_W-1:0] next_top =
      do_packed ? TOP_CLEAR :
      do_fstack ? ret.fpu_top : stack_top_pointer;

   // shared register file write port
   wire              st_we    = (do_packed || do_fstack) && ret.wr;
   wire [FREG_W-1:0] st_wdata = do_packed ?
      {EXP_ONES, ret.data[SIMD_W-1:0]} :
      ret.data;
   wire [FREG_W-1:0] st_rdata;

   sfsa_stack u_stack (
      .clk_sys (clk_sys),
      .we      (st_we),
      .widx    (ret.idx),
      .wdata   (st_wdata),
      .ridx    (cnt),
      .rdata   (st_rdata)
   );

   // save walk; retire is stalled meanwhile so the image is coherent
   wire in_save   = state == ST_SAVE;
   wire save_last = in_save && cnt == LAST_IDX;
   wire next_ready = do_save ? 1'b0 : in_save ? save_last : 1'b1;

   // events and sticky status; a new event wins over a clear
   logic [EV_W-1:0] ev;
   assign ev[EV_EMU]     = f_emu;
   assign ev[EV_UNIMPL]  = f_unimpl;
   assign ev[EV_NOIDENT] = f_noid;
   assign ev[EV_EMPTY]   = do_empty;
   wire [EV_W-1:0] w1c = wr_stat ? hwdata[EV_W-1:0] : '0;
   wire [EV_W-1:0] next_status = (status & ~w1c) | ev;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         wr_pend   <= 1'b0;
         wr_addr   <= A_CTRL;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (rd_take) begin
            hrdata <= rd_mux;
         end
         if (hready) begin
            wr_pend <= wr_take && in_win;
            wr_addr <= a;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         control_reg_zero <= CTRL_RST;
         mask             <= '0;
         status           <= '0;
         irq              <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            control_reg_zero <= hwdata[CTRL_W-1:0];
         end
         if (wr_mask) begin
            mask <= hwdata[EV_W-1:0];
         end
         status <= next_status;
         irq    <= |(status & mask);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tag_word          <= TAGS_EMPTY;
         stack_top_pointer <= TOP_CLEAR;
         resp              <= '0;
      end else begin
         tag_word          <= next_tags;
         stack_top_pointer <= next_top;
         resp.fault        <= invalid_opcode_fault;
         resp.ident_valid  <= do_ident;
         if (do_ident) begin
            resp.ident_d <= ident_val;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state        <= ST_IDLE;
         cnt          <= TOP_CLEAR;
         retire_ready <= 1'b1;
         save         <= '0;
      end else begin
         retire_ready <= next_ready;
         save.valid   <= in_save;
         unique case (state)
            ST_IDLE: begin
               cnt <= TOP_CLEAR;
               if (do_save) begin
                  state <= ST_SAVE;
               end
            end
            ST_SAVE: begin
               save.idx  <= cnt;
               save.data <= st_rdata;
               cnt       <= cnt + 3'h1;
               if (save_last) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_save_burst;
      !save.valid ##1 save.valid [*8] ##1 !save.valid;
   endsequence

   sequence s_fault_quiet;
      resp.fault && $stable(tag_word) && $stable(stack_top_pointer);
   endsequence

   property p_empty_tags;
      do_empty |=> tag_word == TAGS_EMPTY;
   endproperty
   a_empty_tags: assert property (p_empty_tags)
      else $error("empty op did not empty the tags");

   property p_valid_tags;
      do_packed |=> tag_word == TAGS_VALID;
   endproperty
   a_valid_tags: assert property (p_valid_tags)
      else $error("packed op did not validate the tags");

   property p_top_clear;
      do_packed |=> stack_top_pointer == TOP_CLEAR;
   endproperty
   a_top_clear: assert property (p_top_clear)
      else $error("packed op did not clear the stack top");

   // checks the stored word, not the write bus, so a lost write also fires
   property p_exp_force;
      do_packed && ret.wr |=>
         u_stack.mem[$past(ret.idx)][FREG_W-1:SIMD_W] == EXP_ONES;
   endproperty
   a_exp_force: assert property (p_exp_force)
      else $error("packed write left exponent unforced");

   property p_fstack_asis;
      do_fstack |=> tag_word == $past(ret.fpu_tags) &&
                    stack_top_pointer == $past(ret.fpu_top);
   endproperty
   a_fstack_asis: assert property (p_fstack_asis)
      else $error("stack op state was adjusted");

   property p_ident;
      do_ident && ret.leaf == LEAF_FEAT |=> resp.ident_valid &&
         resp.ident_d[FEAT_BIT] == $past(control_reg_zero[CTRL_SIMD]);
   endproperty
   a_ident: assert property (p_ident)
      else $error("ident op feature flag wrong");

   property p_emu_fault;
      acc && is_simd && emu_on |=> s_fault_quiet;
   endproperty
   a_emu_fault: assert property (p_emu_fault)
      else $error("emulation bit did not fault");

   property p_unimpl_fault;
      acc && ret.op == OP_PACKED && !emu_on && !ret.impl |=> s_fault_quiet;
   endproperty
   a_unimpl_fault: assert property (p_unimpl_fault)
      else $error("unimplemented op did not fault");

   property p_noident;
      acc && ret.op == OP_IDENT && !control_reg_zero[CTRL_IDENT]
         |=> resp.fault && !resp.ident_valid;
   endproperty
   a_noident: assert property (p_noident)
      else $error("missing ident op did not fault");

   property p_empty_top;
      do_empty |=> $stable(stack_top_pointer);
   endproperty
   a_empty_top: assert property (p_empty_top)
      else $error("empty op moved the stack top");

   property p_save;
      do_save |=> s_save_burst;
   endproperty
   a_save: assert property (p_save)
      else $error("save image burst malformed");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import sfsa_pkg::*;
   logic                clk_sys = 0;
   logic                rst_n   = 0;
   logic                hsel    = 0;
   logic [31:0]         haddr   = 0;
   logic [1:0]          htrans  = 0;
   logic                hwrite  = 0;
   logic [2:0]          hsize   = 0;
   logic [31:0]         hwdata  = 0;
   wire logic           hreadyout;
   logic                hresp;
   logic [31:0]         hrdata;
   sfsa_retire_s        ret;
   logic                retire_ready;
   sfsa_resp_s          resp;
   sfsa_save_s          save;
   logic [TAGS_W-1:0]   tag_word;
   logic [TOP_W-1:0]    stack_top_pointer;
   logic                irq;
   int                  errors = 0;
   int                  num_checks = 0;
   int                  cycles = 0;
   int                  save_cnt = 0;
   logic [FREG_W-1:0]   img [NREG];
   logic [31:0]         rd;
   logic [63:0]         pk = 64'h0123_4567_89ab_cdef;
   logic [63:0]         pk2 = 64'hfedc_ba98_7654_3210;
   logic [FREG_W-1:0]   raw = 80'h1234_5678_9abc_def0_1357;

   always #4 clk_sys = ~clk_sys;

   sfsa_top sfsa_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ret(ret),
      .retire_ready(retire_ready), .resp(resp), .save(save),
      .tag_word(tag_word), .stack_top_pointer(stack_top_pointer),
      .irq(irq));

   // image words are captured mid-cycle, away from the launching edge
   always @(negedge clk_sys) begin
      if (save.valid === 1'b1) begin
         img[save.idx] = save.data;
         save_cnt++;
      end
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // waits for hready high at a falling edge; data taken there, then steps to the rising edge
   task automatic wait_rdy(output logic [31:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (hreadyout !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      d = hrdata;
      @(posedge clk_sys);
   endtask

   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= 3'h2;
      wait_rdy(d);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(d);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, {24'h0, a}, wd, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, {24'h0, a}, 32'h0, d);
      chk(d, exp);
      chk(hresp, 1'b0);
   endtask

   task automatic retire(input sfsa_op_e op, input logic impl,
                         input logic w, input logic [2:0] idx,
                         input logic [79:0] data, input logic [31:0] leaf,
                         input logic exp_fault);
      int n;
      n = 0;
      ret.valid <= 1'b1;
      ret.op    <= op;
      ret.impl  <= impl;
      ret.wr    <= w;
      ret.idx   <= idx;
      ret.data  <= data;
      ret.leaf  <= leaf;
      @(negedge clk_sys);
      while (retire_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
      ret.valid <= 1'b0;
      @(negedge clk_sys);
      chk(resp.fault, exp_fault);
      chk(resp.ident_valid, op == OP_IDENT && !exp_fault);
      @(posedge clk_sys);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
      @(posedge clk_sys);
   endtask

   initial begin
      ret = '0;
      ret.fpu_tags = 16'h5a5a;
      ret.fpu_top  = 3'h5;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk(tag_word, TAGS_EMPTY);
      rd_chk(A_CTRL, 32'h0000_0006);
      rd_chk(8'h40, 32'h0000_0000);
      wr(A_TAGS, 32'h0000_0000);
      rd_chk(A_TAGS, 32'h0000_ffff);
      wr(A_MASK, 32'h0000_0001);
      retire(OP_FSTACK, 1'b1, 1'b1, 3'h5, raw, 32'h0, 1'b0);
      chk(tag_word, 16'h5a5a);
      chk(stack_top_pointer, 3'h5);
      // stack state saved before packed code starts
      retire(OP_SAVE, 1'b1, 1'b0, 3'h0, 80'h0, 32'h0, 1'b0);
      idle(12);
      chk(img[5], raw);
      retire(OP_EMPTY, 1'b1, 1'b1, 3'h5, 80'h0, 32'h0, 1'b0);
      chk(tag_word, TAGS_EMPTY);
      chk(stack_top_pointer, 3'h5);
      retire(OP_PACKED, 1'b1, 1'b1, 3'h3, {16'h0, pk}, 32'h0,
             1'b0);
      // second packed op with no empty op between them
      retire(OP_PACKED, 1'b1, 1'b1, 3'h4, {16'h0, pk2}, 32'h0,
             1'b0);
      chk(tag_word, TAGS_VALID);
      chk(stack_top_pointer, TOP_CLEAR);
      retire(OP_SAVE, 1'b1, 1'b0, 3'h0, 80'h0, 32'h0, 1'b0);
      chk(retire_ready, 1'b0);
      idle(12);
      chk(save_cnt, 16);
      chk(img[3], {EXP_ONES, pk});
      chk(img[4], {EXP_ONES, pk2});
      chk(img[5], raw);
      retire(OP_EMPTY, 1'b1, 1'b0, 3'h0, 80'h0, 32'h0, 1'b0);
      retire(OP_PACKED, 1'b0, 1'b0, 3'h0, 80'h0, 32'h0, 1'b1);
      chk(tag_word, TAGS_EMPTY);
      chk(irq, 1'b0);
      wr(A_CTRL, 32'h0000_0004);
      retire(OP_PACKED, 1'b1, 1'b0, 3'h0, 80'h0, 32'h0, 1'b1);
      wr(A_CTRL, 32'h0000_0007);
      retire(OP_PACKED, 1'b1, 1'b1, 3'h2, 80'h0, 32'h0, 1'b1);
      chk(tag_word, TAGS_EMPTY);
      idle(1);
      chk(irq, 1'b1);
      wr(A_STAT, 32'h0000_0001);
      idle(2);
      chk(irq, 1'b0);
      // unimpl and empty-done stay; the ident fault has not happened yet
      rd_chk(A_STAT, 32'h0000_000a);
      wr(A_CTRL, 32'h0000_0002);
      retire(OP_IDENT, 1'b1, 1'b0, 3'h0, 80'h0, 32'h1, 1'b1);
      wr(A_CTRL, 32'h0000_0006);
      retire(OP_IDENT, 1'b1, 1'b0, 3'h0, 80'h0, 32'h1, 1'b0);
      chk(resp.ident_d, 32'h0080_0000);
      rd_chk(A_IDENT, 32'h0080_0000);
      retire(OP_IDENT, 1'b1, 1'b0, 3'h0, 80'h0, 32'h2, 1'b0);
      chk(resp.ident_d, 32'h0000_0000);
      // empty op closes the packed routine before stack code runs
      retire(OP_EMPTY, 1'b1, 1'b0, 3'h0, 80'h0, 32'h0, 1'b0);
      retire(OP_FSTACK, 1'b1, 1'b0, 3'h0, 80'h0, 32'h0, 1'b0);
      chk(tag_word, 16'h5a5a);
      end_of_test();
   end
endmodule
